// File: rtl/mls_consts.vh
// constants for the modem line status block
// What this block does
// - bit 7 is inverted carrier detect pin, or user_output_two in loopback
// - bit 6 is inverted ring indicator pin, or user_output_one in loopback
// - bit 5 is inverted data set ready pin, or dtr control bit in loopback
// - bit 4 is inverted clear-to-send pin, or rts control bit in loopback
// - clear-to-send gates the transmitter only when control bit 5 enables it
// - with gating on and pin high (rts control bit clear in loopback), finish current character, start none more
// - flags 3,1,0 set on any change of carrier, data set ready, clear-to-send
// - flag 2 sets only when ring indicator pin rises low to high, or user_output_one goes 1 to 0 in loopback
// - modem interrupt request stands while any of flags 3..0 is one
// - reading the status register clears the change flags
// - after reset flags are zero, upper bits show present input levels
`ifndef MLS_CONSTS_VH
`define MLS_CONSTS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define MLS_OFS_STATUS   5'h00
`define MLS_OFS_CONTROL  5'h04
`define MLS_OFS_TXDATA   5'h08
`define MLS_OFS_DIVISOR  5'h0c
`define MLS_OFS_TXSTATE  5'h10

// ************************************************************
// modem_control_reg fields
// ************************************************************
`define MLS_CTL_DTR      0
`define MLS_CTL_RTS      1
`define MLS_CTL_USER_ONE 2
`define MLS_CTL_USER_TWO 3
`define MLS_CTL_LOOP     4
`define MLS_CTL_AFE      5
`define MLS_CTL_W        6

// ************************************************************
// reset values
// ************************************************************
`define MLS_CTL_RST      6'h00
`define MLS_FLAGS_RST    4'h0
`define MLS_DIV_RST      16'h0010

// ************************************************************
// timing
// ************************************************************
`define MLS_SYNC_STAGES  2
`define MLS_DATA_BITS    8

`endif

// File: rtl/mls_sync.v
// two-stage level synchroniser for the modem inputs
`timescale 1ns/1ps
module mls_sync #(
    parameter W = 4
) (
    // clock
    input  wire         i_ref_clk,
    // asynchronous levels in
    input  wire [W-1:0] i_async,
    // synchronised levels out
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // no reset: data only, and the second stage must track the pins during reset
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_ref_clk) begin
                meta_q[g] <= i_async[g];
                sync_q[g] <= meta_q[g];
            end
        end
    endgenerate

    assign o_sync = sync_q;
endmodule // mls_sync

// File: rtl/mls_modem_status.v
// modem line status register with modem control, loopback and a flow-gated transmitter
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "mls_consts.vh"
module mls_modem_status #(
    parameter DIV_W = 16
) (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst,
    // avalon-mm slave
    input  wire [4:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg         o_waitrequest,
    output reg  [31:0] o_readdata,
    // modem inputs, active low
    input  wire        i_cts_n,
    input  wire        i_dsr_n,
    input  wire        i_ri_n,
    input  wire        i_dcd_n,
    // modem outputs, active low
    output reg         o_dtr_n,
    output reg         o_rts_n,
    output reg         o_user_output_one_n,
    output reg         o_user_output_two_n,
    // serial data and interrupt request
    output reg         o_txd,
    output reg         o_modem_int
);

    // ************************************************************
    // decoding
    // ************************************************************
    function hit;
        input [4:0] addr;
        input [4:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_DATA  = 2'h2;
    localparam [1:0] ST_STOP  = 2'h3;

    reg  [`MLS_CTL_W-1:0] ctl_q;
    reg  [3:0]            flags_q;
    reg  [3:0]            flags_d;
    reg  [3:0]            lvl_prev_q;
    reg  [DIV_W-1:0]      div_q;
    reg  [7:0]            hold_q;
    reg                   hold_full_q;
    reg  [1:0]            state_q;
    reg  [DIV_W-1:0]      cnt_q;
    reg  [2:0]            bit_q;
    reg  [7:0]            sh_q;
    reg                   line_q;
    reg  [31:0]           rd_mux;
    reg  [3:0]            clr_mask;

    wire [3:0]            pin_sync;
    wire [3:0]            lvl;
    wire [3:0]            chg;
    wire                  loop;
    wire                  req;
    wire                  acc;
    wire                  wr_acc;
    wire                  stall;
    wire                  tick;
    wire [DIV_W-1:0]      cnt_load;
    genvar                g;

    // ************************************************************
    // input synchroniser
    // ************************************************************
    // only the second stage is read, the first may still be settling
    mls_sync #(
        .W (4)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_async   ({i_dcd_n, i_ri_n, i_dsr_n, i_cts_n}),
        .o_sync    (pin_sync)
    );

    // ************************************************************
    // status levels and change detection
    // ************************************************************
    assign loop = ctl_q[`MLS_CTL_LOOP];

    // bit order {carrier, ring, data set ready, clear-to-send}
    assign lvl = loop ? {ctl_q[`MLS_CTL_USER_TWO],
                         ctl_q[`MLS_CTL_USER_ONE],
                         ctl_q[`MLS_CTL_DTR],
                         ctl_q[`MLS_CTL_RTS]}
                      : ~pin_sync;

    // ring pin rising means the inverted level falls
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chg
            if (g == 2) begin : g_trail
                assign chg[g] = lvl_prev_q[g] & ~lvl[g];
            end else begin : g_any
                assign chg[g] = lvl[g] ^ lvl_prev_q[g];
            end
        end
    endgenerate

    // ************************************************************
    // bus handshake
    // ************************************************************
    // one wait cycle: the read value is captured while waitrequest is high,
    // the access completes at the edge where it is low
    assign req    = i_read | i_write;
    assign acc    = req & ~o_waitrequest;
    assign wr_acc = acc & i_write;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
        end else if (acc) begin
            o_waitrequest <= 1'b1;
        end else begin
            o_waitrequest <= ~req;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // narrow registers read zero above their width
    always @* begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit(i_address, `MLS_OFS_STATUS):  rd_mux[7:0] = {lvl, flags_q};
            hit(i_address, `MLS_OFS_CONTROL): rd_mux[`MLS_CTL_W-1:0] = ctl_q;
            hit(i_address, `MLS_OFS_DIVISOR): rd_mux[DIV_W-1:0] = div_q;
            hit(i_address, `MLS_OFS_TXSTATE): rd_mux[3:0] = {o_modem_int, stall,
                                                             hold_full_q,
                                                             state_q != ST_IDLE};
            default:                          rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_readdata <= 32'h0000_0000;
        end else if (req & o_waitrequest) begin
            o_readdata <= i_read ? rd_mux : 32'h0000_0000;
        end
    end

    // ************************************************************
    // change flags and interrupt request
    // ************************************************************
    // only flags that were reported are cleared, so a change arriving during
    // the read survives; a new change in the clearing cycle also wins
    always @* begin
        clr_mask = 4'h0;
        if (acc & i_read & hit(i_address, `MLS_OFS_STATUS)) begin
            clr_mask = o_readdata[3:0];
        end
        flags_d = (flags_q & ~clr_mask) | chg;
    end

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            flags_q     <= `MLS_FLAGS_RST;
            lvl_prev_q  <= lvl;
        end else begin
            flags_q     <= flags_d;
            lvl_prev_q  <= lvl;
        end
    end

    // ************************************************************
    // interrupt request
    // ************************************************************
    // taken from the next flag value so the request rises with the flag
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_modem_int <= 1'b0;
        end else begin
            o_modem_int <= |flags_d;
        end
    end

    // ************************************************************
    // control and divisor registers
    // ************************************************************
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctl_q <= `MLS_CTL_RST;
            div_q <= `MLS_DIV_RST;
        end else if (wr_acc) begin
            if (hit(i_address, `MLS_OFS_CONTROL) & i_byteenable[0]) begin
                ctl_q <= i_writedata[`MLS_CTL_W-1:0];
            end
            // byte lanes let software update one half of the divisor
            if (hit(i_address, `MLS_OFS_DIVISOR)) begin
                if (i_byteenable[0]) begin
                    div_q[7:0] <= i_writedata[7:0];
                end
                if (i_byteenable[1]) begin
                    div_q[DIV_W-1:8] <= i_writedata[DIV_W-1:8];
                end
            end
        end
    end

    // ************************************************************
    // modem control outputs
    // ************************************************************
    // modem outputs go inactive in loopback, the bits loop back internally
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_dtr_n             <= 1'b1;
            o_rts_n             <= 1'b1;
            o_user_output_one_n <= 1'b1;
            o_user_output_two_n <= 1'b1;
            o_txd               <= 1'b1;
        end else begin
            o_dtr_n             <= loop | ~ctl_q[`MLS_CTL_DTR];
            o_rts_n             <= loop | ~ctl_q[`MLS_CTL_RTS];
            o_user_output_one_n <= loop | ~ctl_q[`MLS_CTL_USER_ONE];
            o_user_output_two_n <= loop | ~ctl_q[`MLS_CTL_USER_TWO];
            o_txd               <= loop | line_q;
        end
    end

    // ************************************************************
    // transmitter, 8 data bits, one stop bit
    // ************************************************************
    // one holding byte in front of the shifter, no fifo
    // clear-to-send pin high reads as level 0
    assign stall    = ctl_q[`MLS_CTL_AFE] & ~lvl[0];
    // a divisor of zero runs as one, so the bit timer never stops
    assign tick     = (cnt_q == {DIV_W{1'b0}});
    assign cnt_load = (div_q == {DIV_W{1'b0}}) ? {DIV_W{1'b0}}
                                               : div_q - {{(DIV_W-1){1'b0}}, 1'b1};

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
            state_q     <= ST_IDLE;
            cnt_q       <= {DIV_W{1'b0}};
            bit_q       <= 3'h0;
            sh_q        <= 8'h00;
            line_q      <= 1'b1;
        end else begin
            // a write while the holding byte is still full is dropped
            if (wr_acc & hit(i_address, `MLS_OFS_TXDATA) & i_byteenable[0]
                & ~hold_full_q) begin
                hold_q      <= i_writedata[7:0];
                hold_full_q <= 1'b1;
            end
            cnt_q <= tick ? cnt_load : cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
            case (state_q)
                ST_IDLE: begin
                    line_q <= 1'b1;
                    if (hold_full_q & ~stall) begin
                        sh_q        <= hold_q;
                        hold_full_q <= 1'b0;
                        line_q      <= 1'b0;
                        cnt_q       <= cnt_load;
                        state_q     <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        line_q  <= sh_q[0];
                        sh_q    <= {1'b0, sh_q[7:1]};
                        bit_q   <= 3'h0;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // a stall here does not cut the character short
                    if (tick) begin
                        if (bit_q == 3'h7) begin
                            line_q  <= 1'b1;
                            state_q <= ST_STOP;
                        end else begin
                            line_q <= sh_q[0];
                            sh_q   <= {1'b0, sh_q[7:1]};
                            bit_q  <= bit_q + 3'h1;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mls_modem_status

// File: verif/mls_chk_asserts.sv
// concurrent checks on the modem line status ports
`timescale 1ns/1ps
module mls_chk (
    // clock and reset
    input wire        i_ref_clk,
    input wire        i_rst,
    // avalon-mm slave
    input wire [4:0]  i_address,
    input wire        i_read,
    input wire        i_write,
    input wire [31:0] i_writedata,
    input wire [3:0]  i_byteenable,
    input wire        o_waitrequest,
    input wire [31:0] o_readdata,
    // modem side
    input wire        i_cts_n,
    input wire        i_dsr_n,
    input wire        i_ri_n,
    input wire        i_dcd_n,
    input wire        o_txd,
    input wire        o_modem_int
);
    // ************************************************************
    // helper state
    // ************************************************************
    logic [5:0] ctl_q;
    logic [3:0] pin_q;
    logic [7:0] still_q, quiet_q, flow_q;
    wire  [3:0] pins   = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
    wire        done   = (i_read | i_write) & ~o_waitrequest;
    wire        ctl_wr = done & i_write & (i_address == 5'h04) & i_byteenable[0];
    wire        st_rd  = done & i_read & (i_address == 5'h00);
    // a falling ring pin is no event, so it must not disturb the quiet count
    wire        evt    = (pins[3] ^ pin_q[3]) | (pins[1:0] != pin_q[1:0])
                       | (pins[2] & ~pin_q[2]) | ctl_wr;
    always_ff @(posedge i_ref_clk) begin
        pin_q <= pins;
        if (i_rst) begin
            ctl_q   <= 6'h00;
            still_q <= 8'h00;
            quiet_q <= 8'h00;
            flow_q  <= 8'h00;
        end else begin
            if (ctl_wr) ctl_q <= i_writedata[5:0];
            still_q <= (ctl_wr | (pins != pin_q)) ? 8'h00 : still_q + {7'h0, ~&still_q};
            quiet_q <= evt ? 8'h00 : quiet_q + {7'h0, ~&quiet_q};
            flow_q  <= (ctl_q[5] & ~ctl_q[4] & i_cts_n) ? flow_q + {7'h0, ~&flow_q} : 8'h00;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_norm_bits;
        st_rd && !ctl_q[4] && still_q > 3 |-> o_readdata[7:4] == ~pins;
    endproperty
    a_norm_bits: assert property (p_norm_bits) else $error("status levels wrong");
    property p_loop_bits;
        st_rd && ctl_q[4] && still_q > 3 |->
            o_readdata[7:4] == {ctl_q[3], ctl_q[2], ctl_q[0], ctl_q[1]};
    endproperty
    a_loop_bits: assert property (p_loop_bits) else $error("loop levels wrong");
    property p_change_int;
        ($changed(i_dcd_n) || $changed(i_dsr_n) || $changed(i_cts_n)) && !ctl_q[4]
            |-> ##[1:4] o_modem_int;
    endproperty
    a_change_int: assert property (p_change_int) else $error("change not flagged");
    property p_ri_rise;
        $rose(i_ri_n) && !ctl_q[4] |-> ##[1:4] o_modem_int;
    endproperty
    a_ri_rise: assert property (p_ri_rise) else $error("ring rise not flagged");
    property p_quiet;
        quiet_q > 4 && !$past(o_modem_int) |-> !o_modem_int;
    endproperty
    a_quiet: assert property (p_quiet) else $error("spurious interrupt");
    property p_read_clear;
        st_rd && quiet_q > 4 |=> !o_modem_int;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared");
    property p_reset_flags;
        $fell(i_rst) |-> !o_modem_int [*3];
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flag after reset");
    property p_flow;
        flow_q > 200 |-> o_txd;
    endproperty
    a_flow: assert property (p_flow) else $error("sent while gated");
    c_flags: cover property (st_rd && o_readdata[3:0] != 4'h0);
    c_loop: cover property (st_rd && ctl_q[4]);
    c_flow: cover property (flow_q > 200);
endmodule // mls_chk

bind mls_modem_status mls_chk u_chk (.i_ref_clk, .i_rst, .i_address, .i_read, .i_write,
    .i_writedata, .i_byteenable, .o_waitrequest, .o_readdata, .i_cts_n, .i_dsr_n,
    .i_ri_n, .i_dcd_n, .o_txd, .o_modem_int);

// File: verif/mls_modem_model.sv
// modem partner driving the four active-low status lines
`timescale 1ns/1ps
module mls_modem_model (
    // modem lines, active low
    output logic o_dcd_n,
    output logic o_ri_n,
    output logic o_dsr_n,
    output logic o_cts_n
);
    // lines idle inactive until the bench asks otherwise
    initial {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} = 4'hf;
    // call right after a rising edge; order dcd ri dsr cts
    task automatic drive(input logic [3:0] lv);
        {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} <= lv;
    endtask
endmodule // mls_modem_model

// File: verif/tb.sv
// self-checking bench for the modem line status block
`timescale 1ns/1ps
module tb;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [4:0]  i_address = 5'h00;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0]  i_byteenable = 4'h0;
    logic [31:0] o_readdata, rd;
    logic        o_waitrequest, o_txd, o_modem_int;
    wire         cts_n, dsr_n, ri_n, dcd_n;
    wire [3:0]   mdm_out_n;
    int          err_count = 0, checks = 0, cyc = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    mls_modem_model u_modem (.o_dcd_n(dcd_n), .o_ri_n(ri_n), .o_dsr_n(dsr_n), .o_cts_n(cts_n));
    mls_modem_status u_dut (.i_ref_clk, .i_rst, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .o_waitrequest, .o_readdata, .i_cts_n(cts_n), .i_dsr_n(dsr_n),
        .i_ri_n(ri_n), .i_dcd_n(dcd_n), .o_dtr_n(mdm_out_n[0]), .o_rts_n(mdm_out_n[1]),
        .o_user_output_one_n(mdm_out_n[2]), .o_user_output_two_n(mdm_out_n[3]),
        .o_txd, .o_modem_int);
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic test_done;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access; a gap edge after it keeps requests apart
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= 4'hf;
        i_write <= wr;
        i_read <= ~wr;
        do @(posedge i_ref_clk); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic pins(input logic [3:0] lv);
        u_modem.drive(lv);
        repeat (6) @(posedge i_ref_clk);
    endtask
    // cut a hang short
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done;
        end
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        bus(1'b0, 5'h00, 32'h0);
        chk("reset status", rd, 32'h0);
        pins(4'h4);
        chk("int set", o_modem_int, 32'h1);
        bus(1'b0, 5'h00, 32'h0);
        chk("changes", rd, 32'hbb);
        bus(1'b0, 5'h00, 32'h0);
        chk("cleared", rd, 32'hb0);
        chk("int clear", o_modem_int, 32'h0);
        pins(4'h0);
        chk("ri fall int", o_modem_int, 32'h0);
        bus(1'b0, 5'h00, 32'h0);
        chk("ri fall", rd, 32'hf0);
        pins(4'h4);
        bus(1'b0, 5'h00, 32'h0);
        chk("ri rise", rd, 32'hb4);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 5'h04, (i == 0) ? 32'h15 : 32'h1a);
            repeat (6) @(posedge i_ref_clk);
            chk("loop outs", mdm_out_n, 32'hf);
            bus(1'b0, 5'h00, 32'h0);
            bus(1'b0, 5'h00, 32'h0);
            chk("loop", rd, (i == 0) ? 32'h60 : 32'h90);
        end
        // outputs follow the control bits one edge after the write lands
        bus(1'b1, 5'h04, 32'h0f);
        @(posedge i_ref_clk);
        chk("modem outs", mdm_out_n, 32'h0);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", rd, 32'h0);
        // gated start: cts pin high holds the character back
        pins(4'h5);
        bus(1'b0, 5'h00, 32'h0);
        bus(1'b1, 5'h04, 32'h20);
        bus(1'b1, 5'h08, 32'h55);
        repeat (300) @(posedge i_ref_clk);
        chk("gated", o_txd, 32'h1);
        u_modem.drive(4'h4);
        for (int i = 0; i < 400 && o_txd !== 1'b0; i++) @(posedge i_ref_clk);
        chk("released", o_txd, 32'h0);
        // without auto flow the pin level is ignored
        repeat (250) @(posedge i_ref_clk);
        pins(4'h5);
        bus(1'b1, 5'h04, 32'h0);
        bus(1'b1, 5'h08, 32'haa);
        for (int i = 0; i < 400 && o_txd !== 1'b0; i++) @(posedge i_ref_clk);
        chk("ungated", o_txd, 32'h0);
        // reset in mid-run: flags clear, upper bits keep showing the pins
        i_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        chk("reset outs", mdm_out_n, 32'hf);
        bus(1'b0, 5'h00, 32'h0);
        chk("rerun status", rd, 32'ha0);
        test_done;
    end
endmodule // tb
